// File: hdl/ep_irq_ctrl.sv
// Endpoint interrupt status, clear sequencer, set and fast/slow routing.
// Assumes an APB master on pclk and a protocol engine command channel on pclk.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps

// Overview of operation
// - A one written to the clear register clears that endpoint status bit.
// - Per cleared endpoint, drop the data-full flag, then issue select/clear command.
// - On command completion set the data-full flag and load endpoint status.
// - Several cleared endpoints are served from highest number to lowest.
// - Sequencer moves to the next endpoint without waiting for software reads.
// - Clear and command handshake runs on the engine clock, tied to the flag.
// - A one written to the set register sets that endpoint status bit.
// - Routing bit one sends the endpoint to fast, zero to slow.
// - Any number of endpoints may share the fast or the slow bit.
// - Device priority setting sends the fast status bit to irq_fast; when clear it goes to irq.
// - Clear, set and routing registers are write-only and reset to zero.
// - Receive sets on good packet; transmit on success or enabled NAK.
// - Only enabled status bits reach the fast or slow device bit.
module ep_irq_ctrl
  import ep_irq_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] ep_rx_ok,
  input  wire logic [31:0] ep_tx_ok,
  input  wire logic [31:0] ep_tx_nak,
  output logic             cmd_valid,
  output logic      [7:0]  cmd_code,
  input  wire logic        cmd_ready,
  input  wire logic        cmd_done,
  input  wire logic [7:0]  cmd_status,
  output logic             irq,
  output logic             irq_fast
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [4:0] highest_set(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 32; i++)
    begin
      if (v[i])
        r = 5'(i);
    end
    return r;
  endfunction : highest_set

  function automatic logic is_mapped(input logic [31:0] a);
    return a == DEV_STATUS_ADDR || a == DEV_MASK_ADDR || a == CMD_DATA_ADDR ||
           a == DEV_PRIO_ADDR || a == EP_STATE_ADDR || a == EP_ENABLE_ADDR ||
           a == EP_CLEAR_ADDR || a == EP_SET_ADDR || a == EP_ROUTE_ADDR ||
           a == CTRL_ADDR;
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic [31:0] prdata_ff,    nxt_prdata;
  logic        pready_ff,    nxt_pready;
  logic        pslverr_ff,   nxt_pslverr;
  logic [31:0] ep_state_ff,  nxt_ep_state;
  logic [31:0] ep_enable_ff, nxt_ep_enable;
  logic [31:0] ep_route_ff,  nxt_ep_route;
  logic [31:0] pending_ff,   nxt_pending;
  logic [2:0]  dev_status_ff, nxt_dev_status;
  logic [2:0]  dev_mask_ff,  nxt_dev_mask;
  logic        dev_prio_ff,  nxt_dev_prio;
  logic        nak_en_ff,    nxt_nak_en;
  logic [7:0]  cmd_data_ff,  nxt_cmd_data;
  logic [4:0]  ep_idx_ff,    nxt_ep_idx;
  logic        cmd_valid_ff, nxt_cmd_valid;
  logic [7:0]  cmd_code_ff,  nxt_cmd_code;
  logic        irq_ff,       nxt_irq;
  logic        irq_fast_ff,  nxt_irq_fast;
  clr_state_t  st_ff,        nxt_st;

  logic        wr;
  logic [31:0] clr_w;
  logic [31:0] set_w;
  logic [31:0] hw_event;
  logic [2:0]  dev_w1c;
  logic [2:0]  dev_set;
  logic        hw_drop;
  logic [31:0] rd_val;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb
  begin
    wr      = psel && penable && pready_ff && pwrite;
    clr_w   = (wr && paddr == EP_CLEAR_ADDR) ? pwdata : REG_RESET;
    set_w   = (wr && paddr == EP_SET_ADDR) ? pwdata : REG_RESET;
    dev_w1c = (wr && paddr == DEV_STATUS_ADDR) ? pwdata[2:0] : DEV_RESET;
    hw_event = ((ep_rx_ok & RX_BITS) |
                ((ep_tx_ok | (ep_tx_nak & {32{nak_en_ff}})) & TX_BITS)) & ~ISO_BITS;

    unique case (paddr)
      DEV_STATUS_ADDR: rd_val = {29'h0000_0000, dev_status_ff};
      DEV_MASK_ADDR:   rd_val = {29'h0000_0000, dev_mask_ff};
      CMD_DATA_ADDR:   rd_val = {24'h00_0000, cmd_data_ff};
      DEV_PRIO_ADDR:   rd_val = {31'h0000_0000, dev_prio_ff};
      EP_STATE_ADDR:   rd_val = ep_state_ff;
      EP_ENABLE_ADDR:  rd_val = ep_enable_ff;
      CTRL_ADDR:       rd_val = {31'h0000_0000, nak_en_ff};
      default:         rd_val = REG_RESET;
    endcase

    nxt_prdata  = prdata_ff;
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    if (psel && penable && !pready_ff)
    begin
      nxt_pready  = 1'b1;
      nxt_prdata  = pwrite ? REG_RESET : rd_val;
      nxt_pslverr = !is_mapped(paddr);
    end

    nxt_ep_state  = (ep_state_ff & ~clr_w) | set_w | hw_event;
    nxt_ep_enable = (wr && paddr == EP_ENABLE_ADDR) ? pwdata : ep_enable_ff;
    nxt_ep_route  = (wr && paddr == EP_ROUTE_ADDR) ? pwdata : ep_route_ff;
    nxt_dev_mask  = (wr && paddr == DEV_MASK_ADDR) ? pwdata[2:0] : dev_mask_ff;
    nxt_dev_prio  = (wr && paddr == DEV_PRIO_ADDR) ? pwdata[PRIO_POS] : dev_prio_ff;
    nxt_nak_en    = (wr && paddr == CTRL_ADDR) ? pwdata[NAK_POS] : nak_en_ff;

    nxt_pending   = pending_ff | clr_w;
    nxt_st        = st_ff;
    nxt_ep_idx    = ep_idx_ff;
    nxt_cmd_valid = cmd_valid_ff;
    nxt_cmd_code  = cmd_code_ff;
    nxt_cmd_data  = cmd_data_ff;
    hw_drop       = 1'b0;
    dev_set       = DEV_RESET;
    unique case (st_ff)
      ST_IDLE:
      begin
        if (|pending_ff)
        begin
          nxt_ep_idx = highest_set(pending_ff);
          nxt_pending[highest_set(pending_ff)] = clr_w[highest_set(pending_ff)];
          hw_drop = 1'b1;
          nxt_st = ST_DROP;
        end
      end
      ST_DROP:
      begin
        nxt_cmd_valid = 1'b1;
        nxt_cmd_code  = CMD_SEL_CLR_BASE + {3'h0, ep_idx_ff};
        nxt_st = ST_ISSUE;
      end
      ST_ISSUE:
      begin
        if (cmd_ready)
        begin
          nxt_cmd_valid = 1'b0;
          nxt_st = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (cmd_done)
        begin
          nxt_cmd_data = cmd_status;
          dev_set[COMMAND_DATA_FULL_FLAG_POS] = 1'b1;
          nxt_st = ST_IDLE;
        end
      end
    endcase

    dev_set[FAST_POS] = |(ep_state_ff & ep_enable_ff & ep_route_ff);
    dev_set[SLOW_POS] = |(ep_state_ff & ep_enable_ff & ~ep_route_ff);
    nxt_dev_status = (dev_status_ff & ~dev_w1c) | dev_set;
    if (hw_drop && !dev_set[COMMAND_DATA_FULL_FLAG_POS])
      nxt_dev_status[COMMAND_DATA_FULL_FLAG_POS] = 1'b0;

    nxt_irq_fast = dev_prio_ff && nxt_dev_status[FAST_POS] && dev_mask_ff[FAST_POS];
    nxt_irq = |(nxt_dev_status & dev_mask_ff & {2'b11, !dev_prio_ff});
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff     <= REG_RESET;
      pready_ff     <= 1'b0;
      pslverr_ff    <= 1'b0;
      ep_state_ff   <= REG_RESET;
      ep_enable_ff  <= REG_RESET;
      ep_route_ff   <= REG_RESET;
      pending_ff    <= REG_RESET;
      dev_status_ff <= DEV_RESET;
      dev_mask_ff   <= DEV_RESET;
      dev_prio_ff   <= 1'b0;
      nak_en_ff     <= 1'b0;
      cmd_data_ff   <= BYTE_RESET;
      ep_idx_ff     <= 5'h00;
      cmd_valid_ff  <= 1'b0;
      cmd_code_ff   <= BYTE_RESET;
      irq_ff        <= 1'b0;
      irq_fast_ff   <= 1'b0;
      st_ff         <= ST_IDLE;
    end
    else if (ce)
    begin
      prdata_ff     <= nxt_prdata;
      pready_ff     <= nxt_pready;
      pslverr_ff    <= nxt_pslverr;
      ep_state_ff   <= nxt_ep_state;
      ep_enable_ff  <= nxt_ep_enable;
      ep_route_ff   <= nxt_ep_route;
      pending_ff    <= nxt_pending;
      dev_status_ff <= nxt_dev_status;
      dev_mask_ff   <= nxt_dev_mask;
      dev_prio_ff   <= nxt_dev_prio;
      nak_en_ff     <= nxt_nak_en;
      cmd_data_ff   <= nxt_cmd_data;
      ep_idx_ff     <= nxt_ep_idx;
      cmd_valid_ff  <= nxt_cmd_valid;
      cmd_code_ff   <= nxt_cmd_code;
      irq_ff        <= nxt_irq;
      irq_fast_ff   <= nxt_irq_fast;
      st_ff         <= nxt_st;
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign cmd_valid = cmd_valid_ff;
  assign cmd_code  = cmd_code_ff;
  assign irq       = irq_ff;
  assign irq_fast  = irq_fast_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_clear_write_clears: assert property (
    ce && |clr_w |=> (ep_state_ff & $past(clr_w & ~set_w & ~hw_event)) == REG_RESET)
    else $error("Cleared endpoint bit still set.");

  a_set_write_sets: assert property (
    ce && |set_w |=> (ep_state_ff & $past(set_w)) == $past(set_w))
    else $error("Set endpoint bit not set.");

  a_event_beats_clear: assert property (
    ce && |(clr_w & hw_event) |=> (ep_state_ff & $past(clr_w & hw_event)) == $past(clr_w & hw_event))
    else $error("Endpoint event lost under a clear.");

  a_flag_low_at_cmd: assert property (
    $rose(cmd_valid_ff) |-> !dev_status_ff[COMMAND_DATA_FULL_FLAG_POS] && $past(st_ff) == ST_DROP)
    else $error("Command issued while data-full flag high.");

  a_cmd_code_value: assert property (
    cmd_valid_ff |-> cmd_code_ff == CMD_SEL_CLR_BASE + {3'h0, ep_idx_ff})
    else $error("Wrong select/clear command code.");

  a_done_loads_status: assert property (
    ce && st_ff == ST_WAIT && cmd_done |=> dev_status_ff[COMMAND_DATA_FULL_FLAG_POS] && cmd_data_ff == $past(cmd_status))
    else $error("Completion did not load status and flag.");

  a_highest_first: assert property (
    ce && st_ff == ST_IDLE && |pending_ff && clr_w == REG_RESET |=> (pending_ff >> ep_idx_ff) == REG_RESET)
    else $error("Endpoint not served highest first.");

  a_next_without_read: assert property (
    (ce && st_ff == ST_WAIT && cmd_done && |pending_ff) ##1 ce |=> st_ff == ST_DROP)
    else $error("Sequencer stalled between endpoints.");

  a_fast_routing: assert property (
    ce && |(ep_state_ff & ep_enable_ff & ep_route_ff) |=> dev_status_ff[FAST_POS])
    else $error("Fast endpoint bit not raised.");

  a_slow_routing: assert property (
    ce && |(ep_state_ff & ep_enable_ff & ~ep_route_ff) |=> dev_status_ff[SLOW_POS])
    else $error("Slow endpoint bit not raised.");

  a_wo_reads_zero: assert property (
    pready_ff && !pwrite && (paddr == EP_CLEAR_ADDR || paddr == EP_SET_ADDR || paddr == EP_ROUTE_ADDR) |-> prdata_ff == REG_RESET)
    else $error("Write-only register read back non-zero.");

endmodule : ep_irq_ctrl

// File: hdl/ep_irq_pkg.sv
// Constants for the endpoint interrupt control block.
// Assumes a 32-bit APB bus and a command channel on the same clock.
package ep_irq_pkg;

  localparam logic [31:0] DEV_STATUS_ADDR = 32'he009_0000;
  localparam logic [31:0] DEV_MASK_ADDR   = 32'he009_0004;
  localparam logic [31:0] CMD_DATA_ADDR   = 32'he009_0014;
  localparam logic [31:0] DEV_PRIO_ADDR   = 32'he009_002c;
  localparam logic [31:0] EP_STATE_ADDR   = 32'he009_0030;
  localparam logic [31:0] EP_ENABLE_ADDR  = 32'he009_0034;
  localparam logic [31:0] EP_CLEAR_ADDR   = 32'he009_0038;
  localparam logic [31:0] EP_SET_ADDR     = 32'he009_003c;
  localparam logic [31:0] EP_ROUTE_ADDR   = 32'he009_0040;
  localparam logic [31:0] CTRL_ADDR       = 32'he009_00f0;

  localparam int FAST_POS  = 0;
  localparam int SLOW_POS  = 1;
  localparam int COMMAND_DATA_FULL_FLAG_POS = 2;
  localparam int PRIO_POS  = 0;
  localparam int NAK_POS   = 0;

  localparam logic [31:0] REG_RESET  = 32'h0000_0000;
  localparam logic [2:0]  DEV_RESET  = 3'h0;
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [31:0] RX_BITS    = 32'h5555_5555;
  localparam logic [31:0] TX_BITS    = 32'haaaa_aaaa;
  localparam logic [31:0] ISO_BITS   = 32'h030c_30c0;
  localparam logic [7:0]  CMD_SEL_CLR_BASE = 8'h40;

  typedef enum logic [1:0] {ST_IDLE, ST_DROP, ST_ISSUE, ST_WAIT} clr_state_t;

endpackage : ep_irq_pkg

// File: dv/cmd_engine_model.sv
// Behavioural command engine that answers select/clear commands.
// Assumes it shares pclk with the block; slow stretches every answer.
`timescale 1ns/10ps
module cmd_engine_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       slow,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_code,
  output logic            cmd_ready,
  output logic            cmd_done,
  output logic      [7:0] cmd_status
);
  logic [3:0] cnt_ff;
  logic [7:0] code_ff;
  // The status byte stands only with the done pulse and toggles at other times.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff     <= 4'h0;
      code_ff    <= 8'h00;
      cmd_ready  <= 1'b0;
      cmd_done   <= 1'b0;
      cmd_status <= 8'h00;
    end
    else
    begin
      cmd_ready  <= 1'b0;
      cmd_done   <= 1'b0;
      cmd_status <= ~cmd_status;
      if (cnt_ff != 4'h0)
      begin
        cnt_ff <= cnt_ff - 4'h1;
        if (cnt_ff == 4'h1)
        begin
          cmd_done   <= 1'b1;
          cmd_status <= code_ff ^ 8'h5a;
        end
      end
      else if (cmd_valid && !cmd_ready)
      begin
        cmd_ready <= 1'b1;
        code_ff   <= cmd_code;
        cnt_ff    <= slow ? 4'h7 : 4'h2;
      end
    end
  end
endmodule : cmd_engine_model

// File: dv/tb_usb_endpoint_interrupt_control.sv
// Self-checking bench for the endpoint interrupt control block.
// Assumes the command engine model and the block share pclk.
`timescale 1ns/10ps
module tb_usb_endpoint_interrupt_control
  import ep_irq_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, rx = '0, tx = '0, nak = '0, prdata, rd;
  logic        pready, pslverr, cmd_valid, cmd_ready, cmd_done, irq, irq_fast, err;
  logic        ce = 1'b1;
  logic [7:0]  cmd_code, cmd_status;
  logic [31:0] rnd = 32'h0000_cd10, exp_state = '0;
  logic [31:0] wo [3] = '{EP_CLEAR_ADDR, EP_SET_ADDR, EP_ROUTE_ADDR};
  logic [7:0]  codes [$];
  int          num_errors = 0, n_checks = 0, k;
  always #10 pclk = ~pclk;
  ep_irq_ctrl dut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ep_rx_ok(rx), .ep_tx_ok(tx), .ep_tx_nak(nak), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_status(cmd_status),
    .irq(irq), .irq_fast(irq_fast));
  cmd_engine_model engine (.pclk(pclk), .presetn(presetn), .slow(slow), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_status(cmd_status));
  always @(posedge pclk)
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
      codes.push_back(cmd_code);
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Clears endpoints, then compares command order, final data and status.
  task automatic clr(input logic [31:0] c);
    int i;
    int lo;
    codes.delete();
    apb(1'b1, EP_CLEAR_ADDR, c);
    exp_state &= ~c;
    do apb(1'b0, DEV_STATUS_ADDR, '0);
    while (rd[COMMAND_DATA_FULL_FLAG_POS] !== 1'b1 || codes.size() < $countones(c));
    for (i = 31; i >= 0; i--)
      if (c[i])
      begin
        chk({24'h0, codes.pop_front()}, 32'(i) + 32'h0000_0040);
        lo = i;
      end
    apb(1'b0, CMD_DATA_ADDR, '0);
    chk(rd, {24'h0, 8'(lo + 64) ^ 8'h5a});
    apb(1'b0, EP_STATE_ADDR, '0);
    chk(rd, exp_state);
  endtask : clr
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_sim();
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (wo[i])
    begin
      apb(1'b0, wo[i], '0);
      chk(rd, REG_RESET);
    end
    apb(1'b0, 32'he009_0100, '0);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, REG_RESET);
    $display("test registers done");
    for (k = 0; k < 4; k++)
    begin
      rnd = xs(rnd);
      apb(1'b1, EP_SET_ADDR, rnd);
      exp_state |= rnd;
      apb(1'b0, EP_STATE_ADDR, '0);
      chk(rd, exp_state);
      slow <= k[0];
      rnd = xs(rnd);
      clr(k == 0 ? 32'h0000_0420 : (exp_state & rnd & 32'h00ff_00ff) | 32'h1);
    end
    clr(exp_state | 32'h1);
    $display("test clear sequence done");
    apb(1'b1, EP_ENABLE_ADDR, 32'hffff_ffff);
    apb(1'b1, DEV_MASK_ADDR, 32'h0000_0003);
    for (k = 0; k < 4; k++)
    begin
      apb(1'b1, DEV_STATUS_ADDR, 32'h0000_0003);
      if (k > 0)
        apb(1'b1, EP_ROUTE_ADDR, k[0] ? 32'h0000_0300 : '0);
      apb(1'b1, DEV_PRIO_ADDR, {31'h0, k[1]});
      apb(1'b1, EP_SET_ADDR, 32'h0000_0300);
      exp_state |= 32'h0000_0300;
      apb(1'b0, DEV_STATUS_ADDR, '0);
      chk({30'h0, rd[1:0]}, {30'h0, ~k[0], k[0]});
      chk({30'h0, irq, irq_fast}, {30'h0, ~(k[0] & k[1]), k[0] & k[1]});
      clr(32'h0000_0300);
    end
    apb(1'b1, EP_ENABLE_ADDR, '0);
    apb(1'b1, DEV_STATUS_ADDR, 32'h0000_0003);
    apb(1'b1, EP_SET_ADDR, 32'h0000_0100);
    exp_state |= 32'h0000_0100;
    apb(1'b0, DEV_STATUS_ADDR, '0);
    chk({30'h0, rd[1:0]}, 32'h0);
    $display("test routing done");
    nak <= 32'h0000_0020;
    @(posedge pclk);
    nak <= '0;
    apb(1'b1, CTRL_ADDR, 32'h0000_0001);
    rx  <= 32'h0000_0041;
    nak <= 32'h0000_0002;
    tx  <= 32'h0000_0008;
    @(posedge pclk);
    rx  <= '0;
    nak <= '0;
    tx  <= '0;
    apb(1'b0, EP_STATE_ADDR, '0);
    exp_state |= 32'h0000_000b;
    chk(rd, exp_state);
    $display("test events done");
    for (k = 0; k < 4; k++)
      if (exp_state[k])
        clr(32'h0000_0001 << k);
    ce <= 1'b0;
    rx <= 32'h0000_0010;
    @(posedge pclk);
    ce <= 1'b1;
    rx <= '0;
    apb(1'b0, EP_STATE_ADDR, '0);
    chk(rd, exp_state);
    fork
      clr(32'h0000_0010);
      begin
        repeat (3) @(posedge pclk);
        rx <= 32'h0000_0010;
        @(posedge pclk);
        rx <= '0;
        @(posedge pclk);
        exp_state |= 32'h0000_0010;
      end
    join
    $display("test single clears done");
    end_sim();
  end
endmodule : tb_usb_endpoint_interrupt_control
